// ### core/dcs_pkg.sv
// package for the detector command and status register bank
// assumes one 100 MHz clock shared by the whole detector core
// Functional notes
// - one bank of 16-bit serial registers
// - base address setting offsets all registers
// - offset 0 command, offsets 1-7 reserved
// - three codes: alarm test, window test, reset
// - offset 9 reads loop milliamps times 1000
// - offset 8 status: fault and alarm flags
// - status test-active, done and heartbeat bits
// - heartbeat inverts every sixteen seconds
// - request rise executes the current code
// - completion sets the done flag
// - request fall clears the done flag
// - function codes 03, 04, 06, 16 only
// - own node address or broadcast zero
// - protocol active thirty seconds after power-up
package dcs_pkg;
    // timing
    localparam longint CLK_HZ = 100_000_000;
    localparam longint HEARTBEAT_S = 16;
    localparam longint STARTUP_S = 30;
    localparam logic [31:0] HEARTBEAT_CYCLES = 32'(HEARTBEAT_S * CLK_HZ);
    localparam logic [31:0] STARTUP_CYCLES = 32'(STARTUP_S * CLK_HZ);
    // register offsets, relative to the base address
    localparam logic [15:0] OFS_COMMAND = 16'h0000;
    localparam logic [15:0] OFS_STATUS = 16'h0008;
    localparam logic [15:0] OFS_LOOP = 16'h0009;
    localparam logic [15:0] BANK_WORDS = 16'h000a;
    localparam logic [15:0] BASE_RESET = 16'h0000;
    // command register fields
    localparam int CMD_REQ_BIT = 15;
    localparam logic [1:0] CODE_NONE = 2'h0;
    localparam logic [1:0] CODE_ALARM_TEST = 2'h1;
    localparam logic [1:0] CODE_WINDOW_TEST = 2'h2;
    localparam logic [1:0] CODE_LATCH_RESET = 2'h3;
    // status register bit positions
    localparam int ST_ALARM = 13;
    localparam int ST_PREALARM = 12;
    localparam int ST_HW_FAULT = 10;
    localparam int ST_OBSCURED = 9;
    localparam int ST_DIRTY = 8;
    localparam int ST_AT_ACTIVE = 5;
    localparam int ST_OPM_ACTIVE = 4;
    localparam int ST_DONE = 1;
    localparam int ST_HEARTBEAT = 0;
    // serial function and exception codes
    localparam logic [7:0] FC_READ_HOLD = 8'h03;
    localparam logic [7:0] FC_READ_INPUT = 8'h04;
    localparam logic [7:0] FC_WRITE_ONE = 8'h06;
    localparam logic [7:0] FC_WRITE_MANY = 8'h10;
    localparam logic [7:0] EXC_NONE = 8'h00;
    localparam logic [7:0] EXC_FUNCTION = 8'h01;
    localparam logic [7:0] EXC_ADDRESS = 8'h02;
    localparam logic [7:0] NODE_BROADCAST = 8'h00;
    localparam logic [7:0] NODE_MAX = 8'hf7;
    // one register access from the frame handler
    typedef struct packed {
        logic valid;
        logic [7:0] node;
        logic [7:0] func;
        logic [15:0] addr;
        logic [15:0] wdata;
    } dcs_req_t;
    // answer to one register access
    typedef struct packed {
        logic valid;
        logic [7:0] exc;
        logic [15:0] rdata;
    } dcs_rsp_t;
    // detector condition flags
    typedef struct packed {
        logic alarm;
        logic prealarm;
        logic hw_fault;
        logic obscured;
        logic dirty;
        logic alarm_test_active;
        logic window_test_active;
    } dcs_cond_t;
    // handshake states
    typedef enum logic [1:0] {
        DCS_IDLE = 2'b00,
        DCS_BUSY = 2'b01,
        DCS_DONE = 2'b10
    } dcs_state_t;
endpackage

// ### core/dcs_regs.sv
// register bank of the detector as seen over the serial slave
// assumes a frame handler that splits frames into one access per word
// and detector logic on the same clock for conditions and acknowledges
`timescale 1ns/100ps
module dcs_regs #(
    parameter logic [31:0] HEARTBEAT_CYCLES = dcs_pkg::HEARTBEAT_CYCLES,
    parameter logic [31:0] STARTUP_CYCLES = dcs_pkg::STARTUP_CYCLES
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic [7:0] node_addr_in,
    input wire logic [15:0] base_addr_in,
    input wire dcs_pkg::dcs_req_t req_in,
    input wire dcs_pkg::dcs_cond_t cond_in,
    input wire logic [15:0] loop_level_in,
    input wire logic cmd_ack_in,
    output dcs_pkg::dcs_rsp_t rsp_out,
    output logic alarm_self_test_out,
    output logic optical_path_monitor_out,
    output logic latch_clear_out,
    output logic protocol_active_out
);
    logic rst_n_meta;
    logic rst_n;
    logic [31:0] start_cnt;
    logic active;
    logic [31:0] hb_cnt;
    logic hb_tick;
    logic heartbeat;
    logic cmd_req;
    logic [1:0] cmd_code;
    logic req_prev;
    logic done;
    dcs_pkg::dcs_state_t state;
    dcs_pkg::dcs_state_t next_state;
    dcs_pkg::dcs_rsp_t next_rsp;
    logic next_at;
    logic next_opm;
    logic next_clr;

    // byte wide equality used by the addressing checks
    function automatic logic same_byte(input logic [7:0] a,
                                       input logic [7:0] b);
        same_byte = (a == b);
    endfunction

    // reset release through two flip-flops
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_n_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_n_meta <= 1'b1;
            rst_n <= rst_n_meta;
        end
    end

    // power-up hold-off before the serial side answers
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            start_cnt <= 32'h0000_0000;
            active <= 1'b0;
        end else if (!active) begin
            start_cnt <= start_cnt + 32'h0000_0001;
            active <= (start_cnt >= STARTUP_CYCLES - 32'h0000_0001);
        end
    end

    // heartbeat divider gives one enable per interval
    assign hb_tick = (hb_cnt == HEARTBEAT_CYCLES - 32'h0000_0001);

    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            hb_cnt <= 32'h0000_0000;
            heartbeat <= 1'b0;
        end else begin
            hb_cnt <= hb_tick ? 32'h0000_0000 : hb_cnt + 32'h0000_0001;
            if (hb_tick) begin
                heartbeat <= ~heartbeat;
            end
        end
    end

    // request decode
    logic broadcast;
    logic for_us;
    logic is_read;
    logic is_write;
    logic fc_ok;
    logic [15:0] index;
    logic in_bank;
    logic take;
    logic wr_cmd;

    assign broadcast = same_byte(req_in.node, dcs_pkg::NODE_BROADCAST);
    assign for_us = broadcast
        || (same_byte(req_in.node, node_addr_in)
            && (node_addr_in <= dcs_pkg::NODE_MAX));
    assign is_read = same_byte(req_in.func, dcs_pkg::FC_READ_HOLD)
        || same_byte(req_in.func, dcs_pkg::FC_READ_INPUT);
    assign is_write = same_byte(req_in.func, dcs_pkg::FC_WRITE_ONE)
        || same_byte(req_in.func, dcs_pkg::FC_WRITE_MANY);
    assign fc_ok = is_read || is_write;
    assign index = req_in.addr - base_addr_in;
    assign in_bank = (index < dcs_pkg::BANK_WORDS);
    // only the registered flag opens the bus, so the master never sees
    // an answer in the cycle before protocol_active_out rises
    assign take = req_in.valid && protocol_active_out && for_us;
    assign wr_cmd = take && is_write && in_bank
        && (index == dcs_pkg::OFS_COMMAND);

    // read data assembly
    logic [15:0] cmd_word;
    logic [15:0] status_word;
    logic [15:0] read_word;

    always_comb begin
        cmd_word = 16'h0000;
        cmd_word[dcs_pkg::CMD_REQ_BIT] = cmd_req;
        cmd_word[1:0] = cmd_code;
    end

    always_comb begin
        status_word = 16'h0000;
        status_word[dcs_pkg::ST_ALARM] = cond_in.alarm;
        status_word[dcs_pkg::ST_PREALARM] = cond_in.prealarm;
        status_word[dcs_pkg::ST_HW_FAULT] = cond_in.hw_fault;
        status_word[dcs_pkg::ST_OBSCURED] = cond_in.obscured;
        status_word[dcs_pkg::ST_DIRTY] = cond_in.dirty;
        status_word[dcs_pkg::ST_AT_ACTIVE] = cond_in.alarm_test_active;
        status_word[dcs_pkg::ST_OPM_ACTIVE] = cond_in.window_test_active;
        status_word[dcs_pkg::ST_DONE] = done;
        status_word[dcs_pkg::ST_HEARTBEAT] = heartbeat;
    end

    // reserved offsets read as zero
    assign read_word = (index == dcs_pkg::OFS_COMMAND) ? cmd_word
        : (index == dcs_pkg::OFS_STATUS) ? status_word
        : (index == dcs_pkg::OFS_LOOP) ? loop_level_in
        : 16'h0000;

    // answer: broadcasts are carried out but never answered
    always_comb begin
        next_rsp = '0;
        next_rsp.valid = take && !broadcast;
        if (!fc_ok) begin
            next_rsp.exc = dcs_pkg::EXC_FUNCTION;
        end else if (!in_bank) begin
            next_rsp.exc = dcs_pkg::EXC_ADDRESS;
        end else if (is_read) begin
            next_rsp.rdata = read_word;
        end else begin
            next_rsp.rdata = req_in.wdata; // write echo
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            rsp_out <= '0;
            protocol_active_out <= 1'b0;
        end else begin
            rsp_out <= next_rsp;
            protocol_active_out <= active;
        end
    end

    // command register; writes to other offsets have no effect
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            cmd_req <= 1'b0;
            cmd_code <= dcs_pkg::CODE_NONE;
        end else if (wr_cmd) begin
            cmd_req <= req_in.wdata[dcs_pkg::CMD_REQ_BIT];
            cmd_code <= req_in.wdata[1:0];
        end
    end

    // request edges
    logic req_rise;
    logic req_fall;

    assign req_rise = cmd_req && !req_prev;
    assign req_fall = !cmd_req && req_prev;

    // handshake sequencing
    always_comb begin
        next_state = state;
        next_at = 1'b0;
        next_opm = 1'b0;
        next_clr = 1'b0;
        case (state)
            dcs_pkg::DCS_IDLE: begin
                if (req_rise) begin
                    next_at = (cmd_code == dcs_pkg::CODE_ALARM_TEST);
                    next_opm = (cmd_code == dcs_pkg::CODE_WINDOW_TEST);
                    next_clr = (cmd_code == dcs_pkg::CODE_LATCH_RESET);
                    next_state = (cmd_code == dcs_pkg::CODE_NONE)
                        ? dcs_pkg::DCS_DONE : dcs_pkg::DCS_BUSY;
                end
            end
            dcs_pkg::DCS_BUSY: begin
                if (cmd_ack_in) begin
                    next_state = dcs_pkg::DCS_DONE;
                end
            end
            dcs_pkg::DCS_DONE: begin
                if (!cmd_req) begin
                    next_state = dcs_pkg::DCS_IDLE;
                end
            end
            default: begin
                next_state = dcs_pkg::DCS_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state <= dcs_pkg::DCS_IDLE;
            req_prev <= 1'b0;
            alarm_self_test_out <= 1'b0;
            optical_path_monitor_out <= 1'b0;
            latch_clear_out <= 1'b0;
        end else begin
            state <= next_state;
            req_prev <= cmd_req;
            alarm_self_test_out <= next_at;
            optical_path_monitor_out <= next_opm;
            latch_clear_out <= next_clr;
        end
    end

    // done flag: a completion in the same cycle as the fall still sets
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            done <= 1'b0;
        end else if (next_state == dcs_pkg::DCS_DONE
                     && state != dcs_pkg::DCS_DONE) begin
            done <= 1'b1;
        end else if (req_fall || state == dcs_pkg::DCS_IDLE) begin
            done <= 1'b0;
        end
    end
endmodule

// ### dv/dcs_properties.sv
// port assertions for the detector register bank
// assumes binding to dcs_regs, one clock domain
`timescale 1ns/100ps
module dcs_properties #(
    parameter logic [31:0] HEARTBEAT_CYCLES = 32'h0000_0020,
    parameter logic [31:0] STARTUP_CYCLES = 32'h0000_0014
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic [7:0] node_addr_in,
    input wire logic [15:0] base_addr_in,
    input wire dcs_pkg::dcs_req_t req_in,
    input wire dcs_pkg::dcs_cond_t cond_in,
    input wire logic [15:0] loop_level_in,
    input wire logic cmd_ack_in,
    input wire dcs_pkg::dcs_rsp_t rsp_out,
    input wire logic alarm_self_test_out,
    input wire logic optical_path_monitor_out,
    input wire logic latch_clear_out,
    input wire logic protocol_active_out
);
    logic [31:0] up_count;
    // decoded view of the request
    wire logic [15:0] idx = 16'(req_in.addr - base_addr_in);
    wire logic ours = req_in.valid && protocol_active_out
        && req_in.node == node_addr_in;
    wire logic fc_ok = req_in.func inside {8'h03, 8'h04, 8'h06, 8'h10};
    wire logic rd_fc = req_in.func inside {8'h03, 8'h04};
    wire logic any_cmd = alarm_self_test_out | optical_path_monitor_out
        | latch_clear_out;
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    // edges since reset release
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) up_count <= 32'h0000_0000;
        else up_count <= up_count + 32'h0000_0001;
    end
    a_ours_answered: assert property (ours |=> rsp_out.valid)
        else $error("access not answered");
    a_bad_function: assert property (ours && !fc_ok |=>
        rsp_out.valid && rsp_out.exc == 8'h01) else $error("bad func");
    a_bad_offset: assert property (ours && fc_ok && idx >= 16'h000a |=>
        rsp_out.exc == 8'h02) else $error("bad offset");
    a_broadcast_quiet: assert property (
        req_in.valid && req_in.node == 8'h00 |=> !rsp_out.valid)
        else $error("broadcast answered");
    a_early_quiet: assert property (
        req_in.valid && !protocol_active_out |=> !rsp_out.valid)
        else $error("answer before active");
    a_loop_value: assert property (ours && rd_fc && idx == 16'h0009 |=>
        rsp_out.rdata == $past(loop_level_in)) else $error("loop level");
    a_status_reserved: assert property (ours && rd_fc &&
        idx == 16'h0008 |=> (rsp_out.rdata & 16'hc8cc) == 16'h0000)
        else $error("status reserved bits");
    a_cmd_pulse: assert property (
        any_cmd |-> $onehot0({alarm_self_test_out, optical_path_monitor_out,
        latch_clear_out}) ##1 !any_cmd) else $error("command pulse");
    a_startup_hold: assert property ($rose(protocol_active_out) |->
        up_count >= STARTUP_CYCLES && up_count <= STARTUP_CYCLES + 32'h6)
        else $error("startup hold-off length");
endmodule
bind dcs_regs dcs_properties #(.HEARTBEAT_CYCLES(HEARTBEAT_CYCLES),
    .STARTUP_CYCLES(STARTUP_CYCLES)) i_dcs_properties (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .node_addr_in(node_addr_in), .base_addr_in(base_addr_in),
    .req_in(req_in), .cond_in(cond_in), .loop_level_in(loop_level_in),
    .cmd_ack_in(cmd_ack_in), .rsp_out(rsp_out),
    .alarm_self_test_out(alarm_self_test_out),
    .optical_path_monitor_out(optical_path_monitor_out),
    .latch_clear_out(latch_clear_out),
    .protocol_active_out(protocol_active_out));

// ### dv/dcs_detector_model.sv
// detector core model that finishes launched commands
// assumes the launch pulses of dcs_regs on the same clock
`timescale 1ns/100ps
module dcs_detector_model #(
    parameter int DELAY = 3
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic start_in,
    output logic cmd_ack_out
);
    logic [7:0] wait_count;
    // one-cycle acknowledge some cycles after a launch
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wait_count <= 8'h00;
            cmd_ack_out <= 1'b0;
        end else begin
            cmd_ack_out <= wait_count == 8'h01;
            if (start_in) wait_count <= 8'(DELAY);
            else if (wait_count != 8'h00) wait_count <= wait_count - 8'h01;
        end
    end
endmodule

// ### dv/tb.sv
// self-checking bench for the detector register bank
// assumes shortened heartbeat and startup counts
`timescale 1ns/100ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
    bad_count++; $display("unexpected %s exp %h got %h", nm, (e), (g)); \
    end end
module tb;
    localparam logic [15:0] BASE = 16'h0100;
    localparam logic [7:0] NODE = 8'h05;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic ack, at_p, opm_p, clr_p, active;
    logic [2:0] seen = 3'h0;
    logic [15:0] loop_level;
    int bad_count = 0;
    int comparisons = 0;
    dcs_pkg::dcs_req_t req;
    dcs_pkg::dcs_cond_t cond;
    dcs_pkg::dcs_rsp_t rsp, r;
    dcs_regs #(.HEARTBEAT_CYCLES(32'h0000_0020),
        .STARTUP_CYCLES(32'h0000_0014)) i_dcs_regs (
        .ref_clk_in(ref_clk), .rst_n_in(rst_n), .node_addr_in(NODE),
        .base_addr_in(BASE), .req_in(req), .cond_in(cond),
        .loop_level_in(loop_level), .cmd_ack_in(ack), .rsp_out(rsp),
        .alarm_self_test_out(at_p), .optical_path_monitor_out(opm_p),
        .latch_clear_out(clr_p), .protocol_active_out(active));
    dcs_detector_model i_dcs_detector_model (.ref_clk_in(ref_clk),
        .rst_n_in(rst_n), .start_in(at_p | opm_p | clr_p), .cmd_ack_out(ack));
    // clock and launch pulse capture
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) seen <= seen | {clr_p, opm_p, at_p};
    task automatic acc(input logic [7:0] nd, fc, input logic [15:0] ad, wd);
        @(posedge ref_clk);
        #1 req = '{1'b1, nd, fc, ad, wd};
        @(posedge ref_clk);
        #1 req.valid = 1'b0;
        r = rsp;
    endtask
    task automatic rd(input logic [15:0] ofs);
        acc(NODE, 8'h03, BASE + ofs, 16'h0000);
    endtask
    task automatic wr(input logic [15:0] ofs, wd);
        acc(NODE, 8'h06, BASE + ofs, wd);
    endtask
    task automatic t_early;
        rd(16'h0009);
        `CHK("early answer", 1'b0, r.valid)
        for (int i = 0; i < 40 && active !== 1'b1; i++) @(posedge ref_clk);
        `CHK("protocol active", 1'b1, active)
    endtask
    task automatic t_regs;
        loop_level = 16'h4268;
        rd(16'h0009);
        `CHK("loop level", 16'h4268, r.rdata)
        cond = 7'h55;
        rd(16'h0008);
        `CHK("status a", 16'h2510, r.rdata & 16'hfffc)
        cond = 7'h2a;
        rd(16'h0008);
        `CHK("status b", 16'h1220, r.rdata & 16'hfffc)
        for (int i = 1; i < 8; i++) begin
            wr(16'(i), 16'hffff);
            rd(16'(i));
            `CHK("reserved word", 16'h0000, r.rdata)
        end
        rd(16'h000a);
        `CHK("range exc", 8'h02, r.exc)
        acc(NODE, 8'h04, 16'h0008, 16'h0000);
        `CHK("unbased exc", 8'h02, r.exc)
        acc(NODE, 8'h05, BASE, 16'h0000);
        `CHK("func exc", 8'h01, r.exc)
        acc(8'h00, 8'h06, BASE + 16'h0001, 16'h0001);
        `CHK("broadcast quiet", 1'b0, r.valid)
        acc(8'h06, 8'h03, BASE, 16'h0000);
        `CHK("other node", 1'b0, r.valid)
    endtask
    task automatic t_cmd(input logic [1:0] code);
        logic [2:0] exp;
        logic [2:0] base;
        exp = (code == 2'h0) ? 3'h0 : 3'(1 << (code - 2'h1));
        rd(16'h0008);
        `CHK("done idle", 1'b0, r.rdata[1])
        wr(16'h0000, {14'h0000, code});
        base = seen;
        wr(16'h0000, {1'b1, 13'h0000, code});
        rd(16'h0008);
        for (int i = 0; i < 20 && r.rdata[1] !== 1'b1; i++) rd(16'h0008);
        `CHK("done set", 1'b1, r.rdata[1])
        `CHK("launch", exp, seen ^ base)
        acc(NODE, 8'h10, BASE, {14'h0000, code});
        rd(16'h0008);
        `CHK("done clear", 1'b0, r.rdata[1])
    endtask
    task automatic t_heartbeat;
        logic hb;
        rd(16'h0008);
        hb = r.rdata[0];
        repeat (30) @(posedge ref_clk);
        rd(16'h0008);
        `CHK("heartbeat", ~hb, r.rdata[0])
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        req = '0;
        cond = '0;
        r = '0;
        loop_level = 16'h0000;
        repeat (6) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        t_early;
        t_regs;
        for (int c = 0; c < 4; c++) t_cmd(2'(c));
        t_heartbeat;
        tally_and_finish;
    end
    // watchdog
    initial begin
        #50000;
        bad_count++;
        tally_and_finish;
    end
endmodule
